/* verilog/sbw_regs.vh */
`ifndef SBW_REGS_VH
`define SBW_REGS_VH
// register byte offsets
`define SBW_OFF_CTRL 8'h00
`define SBW_OFF_TATTR 8'h04
`define SBW_OFF_BASE 8'h08
`define SBW_OFF_CFG 8'h0c
`define SBW_OFF_STAT 8'h10
`define SBW_OFF_NSCONS 8'h14
`define SBW_OFF_SCONS 8'h18
`define SBW_OFF_LSID 8'h1c
// control bits
`define SBW_CTRL_RECINV 0
`define SBW_CTRL_NSRES 1
`define SBW_CTRL_SRES 2
// reset values
`define SBW_TATTR_RST 6'h00
`define SBW_SPLIT_RST 5'h08
`define SBW_BASE_RST 32'h0000_0000
// command opcodes
`define SBW_OP_TLBI 3'h0
`define SBW_OP_ATC 3'h1
`define SBW_OP_CFGI 3'h2
`define SBW_OP_PREF 3'h3
`define SBW_OP_PRI 3'h4
`define SBW_OP_RESUME 3'h5
`define SBW_OP_TERM 3'h6
`define SBW_OP_SYNC 3'h7
// level-1 descriptor layout
`define SBW_L1_SPAN 4:0
`define SBW_L1_RSV_LO 5
`define SBW_L1_PTR 31:6
`define SBW_L1_RSV_HI 63:32
`define SBW_SPAN_MAX 5'h0c
`define SBW_L1_SHIFT 3
// stream table entry layout
`define SBW_STE_V 0
`define SBW_STE_CTXATTR 13:8
`define SBW_STE_RSV 63:56
`define SBW_STE_SHIFT 6
// event codes
`define SBW_EVT_NONE 2'h0
`define SBW_EVT_BAD_SID 2'h1
`define SBW_EVT_BAD_STE 2'h2
`endif

/* verilog/sbw_l1chk.v */
`timescale 1ns/100ps
`include "sbw_regs.vh"
module sbw_l1chk #(
    parameter SIDW = 16
) (
    // descriptor and lookup
    input wire [63:0] desc,
    input wire [SIDW-1:0] sid,
    input wire [4:0] split,
    // verdict
    output reg bad,
    output reg [SIDW-1:0] l2_idx
);
    reg [4:0] span;
    reg [31:0] l2_mask;
    reg [31:0] l2_lim;
    always @*
    begin
        span = desc[`SBW_L1_SPAN];
        l2_mask = (32'h1 << split) - 32'h1;
        l2_idx = sid & l2_mask[SIDW-1:0];
        l2_lim = 32'h1 << (span - 5'h1);
        bad = 1'b0;
        if (span == 5'h0) // [RULE17]
            bad = 1'b1;
        else if (span > `SBW_SPAN_MAX || span > split + 5'h1) // [RULE17]
            bad = 1'b1;
        else if ({{(32-SIDW){1'b0}}, l2_idx} >= l2_lim) // [RULE17]
            bad = 1'b1;
        // non-zero reserved bits make the descriptor invalid
        if (desc[`SBW_L1_RSV_LO] || desc[`SBW_L1_RSV_HI] != 32'h0) // [RULE12]
            bad = 1'b1;
    end
endmodule

/* verilog/sbw_cmdq.v */
`timescale 1ns/100ps
`include "sbw_regs.vh"
module sbw_cmdq #(
    parameter CW = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // queue head
    input wire cmd_valid,
    input wire [2:0] cmd_op,
    output reg cmd_ready_q,
    output reg [CW-1:0] cons_idx_q,
    // issue pulses
    output reg inval_issue_q,
    output reg atc_issue_q,
    output reg stall_resp_q,
    output reg sync_done_q,
    // completions from the downstream engines
    input wire inval_done,
    input wire atc_done,
    input wire atc_fail,
    // error control
    input wire resume,
    output reg sync_err_q
);
    reg [CW-1:0] inval_cnt_q;
    reg [CW-1:0] atc_cnt_q;
    reg fail_seen_q;
    wire head = cmd_valid & ~cmd_ready_q & ~sync_err_q; // [RULE22]
    wire is_sync = cmd_op == `SBW_OP_SYNC;
    wire sync_ok = (inval_cnt_q == {CW{1'b0}}) & (atc_cnt_q == {CW{1'b0}});
    wire take = head & (~is_sync | (sync_ok & ~fail_seen_q));
    wire inc_inv = take & (cmd_op == `SBW_OP_TLBI | cmd_op == `SBW_OP_CFGI);
    wire inc_atc = take & (cmd_op == `SBW_OP_ATC);
    wire dec_inv = inval_done & (inval_cnt_q != {CW{1'b0}});
    wire dec_atc = atc_done & (atc_cnt_q != {CW{1'b0}});
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_ready_q <= 1'b0;
            cons_idx_q <= {CW{1'b0}};
            inval_issue_q <= 1'b0;
            atc_issue_q <= 1'b0;
            stall_resp_q <= 1'b0;
            sync_done_q <= 1'b0;
            sync_err_q <= 1'b0;
            inval_cnt_q <= {CW{1'b0}};
            atc_cnt_q <= {CW{1'b0}};
            fail_seen_q <= 1'b0;
        end
        else
        begin
            // consumption of plain invalidations promises nothing
            cmd_ready_q <= take; // [RULE10]
            cons_idx_q <= cons_idx_q + {{(CW-1){1'b0}}, take};
            inval_issue_q <= inc_inv; // [RULE4]
            atc_issue_q <= inc_atc;
            // stall replies finish as they are consumed
            stall_resp_q <= take & (cmd_op == `SBW_OP_RESUME | cmd_op == `SBW_OP_TERM); // [RULE10]
            // no retry or recording of stalled traffic here
            sync_done_q <= take & is_sync; // [RULE10] [RULE3]
            // error keeps the barrier at the head, no completion sent
            if (head & is_sync & fail_seen_q)
                sync_err_q <= 1'b1; // [RULE5] [RULE6]
            else if (resume)
                sync_err_q <= 1'b0; // [RULE8]
            // pending translation invalidations survive the error
            inval_cnt_q <= inval_cnt_q + {{(CW-1){1'b0}}, inc_inv}
                - {{(CW-1){1'b0}}, dec_inv}; // [RULE9]
            // timed-out device invalidations never return: drop them
            if (resume & sync_err_q)
                atc_cnt_q <= {CW{1'b0}}; // [RULE7]
            else
                atc_cnt_q <= atc_cnt_q + {{(CW-1){1'b0}}, inc_atc}
                    - {{(CW-1){1'b0}}, dec_atc}; // [RULE7]
            if (atc_fail)
                fail_seen_q <= 1'b1;
            else if (resume & sync_err_q)
                fail_seen_q <= 1'b0;
        end
    end
endmodule

/* verilog/sbw_top.v */
// How it works
// [RULE1] each queue's barrier covers its own commands only
// [RULE2] secure queue has its own independent engine
// [RULE3] barrier leaves stalled transactions untouched
// [RULE4] software separates invalidation sets with barriers
// [RULE5] failed device invalidation makes barrier raise error
// [RULE6] errored barrier stays unconsumed, no completion
// [RULE7] timed-out device invalidations are forgotten
// [RULE8] resubmitted barrier completes after resume
// [RULE9] error keeps pending translation invalidations alive
// [RULE10] consumption meaning depends on command kind
// [RULE11] structures are read little-endian always
// [RULE12] non-zero reserved bits invalidate structure
// [RULE13] invalid structure aborts and logs event
// [RULE14] descriptor and entry fetches use table attributes
// [RULE15] context fetch attributes come from entry
// [RULE16] software keeps span within split plus one
// [RULE17] bad span or out-of-range index invalid
// [RULE18] failed lookup aborts, event only if enabled
// [RULE19] software invalidates after descriptor change
// [RULE20] activating zero span needs descriptor invalidation
// [RULE21] deactivating span needs wider invalidation
// [RULE22] queue halts while sync error pending
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "sbw_regs.vh"
module sbw_top #(
    parameter SIDW = 16,
    parameter CW = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // non-secure command queue
    input wire ns_cmd_valid,
    input wire [2:0] ns_cmd_op,
    output wire ns_cmd_ready,
    output wire ns_inval_issue,
    output wire ns_atc_issue,
    output wire ns_stall_resp,
    output wire ns_sync_done,
    input wire ns_inval_done,
    input wire ns_atc_done,
    input wire ns_atc_fail,
    // secure command queue
    input wire s_cmd_valid,
    input wire [2:0] s_cmd_op,
    output wire s_cmd_ready,
    output wire s_inval_issue,
    output wire s_atc_issue,
    output wire s_stall_resp,
    output wire s_sync_done,
    input wire s_inval_done,
    input wire s_atc_done,
    input wire s_atc_fail,
    // client lookup
    input wire tr_valid,
    input wire [SIDW-1:0] tr_sid,
    output reg tr_ready,
    output reg tr_done,
    output reg tr_abort,
    output reg [5:0] cd_fetch_attr,
    // structure fetch
    output reg fetch_req,
    output reg [31:0] fetch_addr,
    output reg [5:0] fetch_attr,
    input wire fetch_valid,
    input wire [63:0] fetch_data,
    // event record
    output reg evt_valid,
    output reg [1:0] evt_code,
    output reg [SIDW-1:0] evt_sid
);
    localparam ST_IDLE = 2'h0;
    localparam ST_L1 = 2'h1;
    localparam ST_STE = 2'h2;

    reg rec_inv_q;
    reg ns_res_q;
    reg s_res_q;
    reg [5:0] tattr_q;
    reg [31:0] base_q;
    reg [4:0] split_q;
    reg [SIDW-1:0] last_sid_q;
    reg [1:0] state_q;
    reg [SIDW-1:0] sid_q;
    wire [CW-1:0] ns_cons;
    wire [CW-1:0] s_cons;
    wire ns_err;
    wire s_err;
    wire l1_bad;
    wire [SIDW-1:0] l2_idx;
    wire [31:0] data_lo;
    wire [31:0] data_hi;
    wire apb_acc;
    wire apb_wr;
    wire [31:0] l1_off;
    wire [31:0] ste_off;
    wire ste_bad;

    // one wait state, then answer from flops
    assign apb_acc = psel & penable & ~pready;
    assign apb_wr = apb_acc & pwrite;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            rec_inv_q <= 1'b0;
            ns_res_q <= 1'b0;
            s_res_q <= 1'b0;
            tattr_q <= `SBW_TATTR_RST;
            base_q <= `SBW_BASE_RST;
            split_q <= `SBW_SPLIT_RST;
        end
        else
        begin
            pready <= apb_acc;
            pslverr <= 1'b0;
            ns_res_q <= 1'b0;
            s_res_q <= 1'b0;
            if (apb_acc)
            begin
                prdata <= 32'h0;
                case (paddr)
                    `SBW_OFF_CTRL:
                    begin
                        if (pwrite)
                        begin
                            rec_inv_q <= pwdata[`SBW_CTRL_RECINV];
                            ns_res_q <= pwdata[`SBW_CTRL_NSRES];
                            s_res_q <= pwdata[`SBW_CTRL_SRES];
                        end
                        else
                            prdata <= {31'h0, rec_inv_q};
                    end
                    `SBW_OFF_TATTR:
                    begin
                        if (pwrite)
                            tattr_q <= pwdata[5:0];
                        else
                            prdata <= {26'h0, tattr_q};
                    end
                    `SBW_OFF_BASE:
                    begin
                        if (pwrite)
                            base_q <= {pwdata[31:`SBW_L1_SHIFT], {`SBW_L1_SHIFT{1'b0}}};
                        else
                            prdata <= base_q;
                    end
                    `SBW_OFF_CFG:
                    begin
                        if (pwrite)
                            split_q <= pwdata[4:0];
                        else
                            prdata <= {27'h0, split_q};
                    end
                    `SBW_OFF_STAT:
                    begin
                        if (!pwrite)
                            prdata <= {30'h0, s_err, ns_err};
                    end
                    `SBW_OFF_NSCONS:
                    begin
                        if (!pwrite)
                            prdata <= {{(32-CW){1'b0}}, ns_cons};
                    end
                    `SBW_OFF_SCONS:
                    begin
                        if (!pwrite)
                            prdata <= {{(32-CW){1'b0}}, s_cons};
                    end
                    `SBW_OFF_LSID:
                    begin
                        if (!pwrite)
                            prdata <= {{(32-SIDW){1'b0}}, last_sid_q};
                    end
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // two independent engines, so secure barriers never wait on
    // non-secure work; secure commands on non-secure structures are
    // counted in the secure engine and so drained by its barrier
    sbw_cmdq #(
        .CW(CW)
    ) u_ns_q (
        .pclk(pclk),
        .presetn(presetn),
        .cmd_valid(ns_cmd_valid),
        .cmd_op(ns_cmd_op),
        .cmd_ready_q(ns_cmd_ready),
        .cons_idx_q(ns_cons),
        .inval_issue_q(ns_inval_issue),
        .atc_issue_q(ns_atc_issue),
        .stall_resp_q(ns_stall_resp),
        .sync_done_q(ns_sync_done),
        .inval_done(ns_inval_done),
        .atc_done(ns_atc_done),
        .atc_fail(ns_atc_fail),
        .resume(ns_res_q),
        .sync_err_q(ns_err)
    ); // [RULE1]

    sbw_cmdq #(
        .CW(CW)
    ) u_s_q (
        .pclk(pclk),
        .presetn(presetn),
        .cmd_valid(s_cmd_valid),
        .cmd_op(s_cmd_op),
        .cmd_ready_q(s_cmd_ready),
        .cons_idx_q(s_cons),
        .inval_issue_q(s_inval_issue),
        .atc_issue_q(s_atc_issue),
        .stall_resp_q(s_stall_resp),
        .sync_done_q(s_sync_done),
        .inval_done(s_inval_done),
        .atc_done(s_atc_done),
        .atc_fail(s_atc_fail),
        .resume(s_res_q),
        .sync_err_q(s_err)
    ); // [RULE1] [RULE2]

    // byte lane 0 is the least significant byte; no swap, whatever
    // the translation table endianness
    assign data_lo = fetch_data[31:0]; // [RULE11]
    assign data_hi = fetch_data[63:32]; // [RULE11]

    sbw_l1chk #(
        .SIDW(SIDW)
    ) u_l1chk (
        .desc({data_hi, data_lo}),
        .sid(sid_q),
        .split(split_q),
        .bad(l1_bad),
        .l2_idx(l2_idx)
    );

    assign l1_off = {{(32-SIDW){1'b0}}, tr_sid >> split_q} << `SBW_L1_SHIFT;
    assign ste_off = {{(32-SIDW){1'b0}}, l2_idx} << `SBW_STE_SHIFT;
    assign ste_bad = ~data_lo[`SBW_STE_V] | (fetch_data[`SBW_STE_RSV] != 8'h0); // [RULE12]

    // walk: level-1 descriptor, then stream table entry
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            sid_q <= {SIDW{1'b0}};
            tr_ready <= 1'b0;
            tr_done <= 1'b0;
            tr_abort <= 1'b0;
            cd_fetch_attr <= 6'h0;
            fetch_req <= 1'b0;
            fetch_addr <= 32'h0;
            fetch_attr <= 6'h0;
            evt_valid <= 1'b0;
            evt_code <= `SBW_EVT_NONE;
            evt_sid <= {SIDW{1'b0}};
            last_sid_q <= {SIDW{1'b0}};
        end
        else
        begin
            tr_done <= 1'b0;
            evt_valid <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    tr_ready <= 1'b1;
                    if (tr_valid & tr_ready)
                    begin
                        tr_ready <= 1'b0;
                        sid_q <= tr_sid;
                        fetch_req <= 1'b1;
                        fetch_addr <= base_q + l1_off;
                        fetch_attr <= tattr_q; // [RULE14]
                        state_q <= ST_L1;
                    end
                end
                ST_L1:
                begin
                    if (fetch_valid)
                    begin
                        if (l1_bad)
                        begin
                            fetch_req <= 1'b0;
                            tr_done <= 1'b1;
                            tr_abort <= 1'b1; // [RULE18]
                            last_sid_q <= sid_q;
                            evt_valid <= rec_inv_q; // [RULE18]
                            evt_code <= `SBW_EVT_BAD_SID;
                            evt_sid <= sid_q;
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            fetch_addr <= {data_lo[`SBW_L1_PTR], 6'h0} + ste_off;
                            fetch_attr <= tattr_q; // [RULE14]
                            state_q <= ST_STE;
                        end
                    end
                end
                ST_STE:
                begin
                    if (fetch_valid)
                    begin
                        fetch_req <= 1'b0;
                        tr_done <= 1'b1;
                        state_q <= ST_IDLE;
                        if (ste_bad)
                        begin
                            tr_abort <= 1'b1; // [RULE13]
                            last_sid_q <= sid_q;
                            evt_valid <= 1'b1; // [RULE13]
                            evt_code <= `SBW_EVT_BAD_STE;
                            evt_sid <= sid_q;
                        end
                        else
                        begin
                            tr_abort <= 1'b0;
                            // later context fetches use these attributes
                            cd_fetch_attr <= data_lo[`SBW_STE_CTXATTR]; // [RULE15]
                        end
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

/* tb/sbw_mem_model.sv */
`timescale 1ns/100ps
module sbw_mem_model (
    // clock and reset
    input logic pclk,
    input logic presetn,
    // fetch port
    input logic fetch_req,
    input logic [31:0] fetch_addr,
    input logic [3:0] lat,
    output logic fetch_valid,
    output logic [63:0] fetch_data
);
    logic [63:0] mem [logic [31:0]];
    logic [3:0] wait_q;
    // data toggles whenever no word is returned
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            fetch_valid <= 1'b0;
            fetch_data <= 64'h0;
            wait_q <= 4'h0;
        end
        else
        begin
            fetch_valid <= 1'b0;
            fetch_data <= ~fetch_data;
            wait_q <= 4'h0;
            if (fetch_req && !fetch_valid && wait_q < lat)
                wait_q <= wait_q + 4'h1;
            else if (fetch_req && !fetch_valid)
            begin
                fetch_valid <= 1'b1;
                fetch_data <= mem.exists(fetch_addr) ? mem[fetch_addr] : 64'h0;
            end
        end
endmodule

/* tb/sbw_top_sva.sv */
`timescale 1ns/100ps
`include "sbw_regs.vh"
module sbw_top_sva (
    // apb
    input logic pclk, presetn, psel, penable, pwrite, pready,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    // queues
    input logic ns_cmd_valid, ns_cmd_ready, ns_atc_issue, ns_stall_resp, ns_sync_done,
    input logic ns_atc_fail, s_atc_fail, s_cmd_valid, s_cmd_ready,
    input logic [2:0] ns_cmd_op, s_cmd_op,
    // lookup
    input logic tr_valid, tr_ready, fetch_req,
    input logic [5:0] fetch_attr
);
    logic nf_q, sf_q, ne_q;
    logic [5:0] ta_q;
    wire wr = psel && penable && !pready && pwrite;
    wire nrs = wr && paddr == `SBW_OFF_CTRL && pwdata[`SBW_CTRL_NSRES];
    wire srs = wr && paddr == `SBW_OFF_CTRL && pwdata[`SBW_CTRL_SRES];
    wire nref = ns_cmd_valid && !ns_cmd_ready && ns_cmd_op == `SBW_OP_SYNC && nf_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            nf_q <= 1'b0;
            sf_q <= 1'b0;
            ne_q <= 1'b0;
            ta_q <= 6'h00;
        end
        else
        begin
            nf_q <= ns_atc_fail || (nf_q && !nrs);
            sf_q <= s_atc_fail || (sf_q && !srs);
            ne_q <= !nrs && (nref || ne_q);
            if (wr && paddr == `SBW_OFF_TATTR)
                ta_q <= pwdata[5:0];
        end
    a_sync_blocked: assert property (nf_q |-> !ns_sync_done)
        else $error("sync completed after a failed device invalidation");
    a_queue_halted: assert property (ne_q |-> !ns_cmd_ready)
        else $error("command consumed while sync error pending");
    a_ns_taken: assert property (ns_cmd_valid && !ns_cmd_ready
        && ns_cmd_op == `SBW_OP_PRI && !nf_q |=> ns_cmd_ready)
        else $error("response command not consumed");
    a_s_free: assert property (s_cmd_valid && !s_cmd_ready && s_cmd_op == `SBW_OP_PREF
        && !sf_q |=> s_cmd_ready) else $error("secure command not consumed");
    a_stall_done: assert property (ns_stall_resp |-> ns_cmd_ready
        && $past(ns_cmd_op) inside {`SBW_OP_RESUME, `SBW_OP_TERM}) else $error("bad stall reply");
    a_atc_issue: assert property (ns_atc_issue |-> ns_cmd_ready
        && $past(ns_cmd_op) == `SBW_OP_ATC) else $error("device invalidation issue mismatch");
    a_fetch_attr: assert property (fetch_req |-> fetch_attr == ta_q)
        else $error("fetch attributes differ from table attributes");
    a_walk_start: assert property (tr_valid && tr_ready |=> fetch_req && !tr_ready)
        else $error("lookup did not start a fetch");
endmodule

/* tb/sbw_top_tb_top.sv */
`timescale 1ns/100ps
`include "sbw_regs.vh"
module sbw_top_tb_top;
    typedef struct {logic [4:0] span; logic [7:0] low; logic [63:0] l1x, ent; logic ab;
        logic [1:0] code;} sbw_row_t;
    sbw_row_t rows [10] = '{
        '{5'h02, 8'h01, 64'h0, 64'h2a01, 1'b0, 2'h0},
        '{5'h02, 8'h02, 64'h0, 64'h2a01, 1'b1, 2'h1},
        '{5'h00, 8'h00, 64'h0, 64'h0001, 1'b1, 2'h1},
        '{5'h0d, 8'h00, 64'h0, 64'h0001, 1'b1, 2'h1},
        '{5'h0a, 8'h00, 64'h0, 64'h0001, 1'b1, 2'h1},
        '{5'h09, 8'hff, 64'h0, 64'h1501, 1'b0, 2'h0},
        '{5'h02, 8'h00, 64'h20, 64'h0001, 1'b1, 2'h1},
        '{5'h02, 8'h00, 64'h100_0000_0000, 64'h0001, 1'b1, 2'h1},
        '{5'h02, 8'h00, 64'h0, 64'h0100_0000_0000_0001, 1'b1, 2'h2},
        '{5'h02, 8'h00, 64'h0, 64'h0, 1'b1, 2'h2}};
    logic [4:0] cexp [8] = '{5'h18, 5'h14, 5'h18, 5'h10, 5'h10, 5'h12, 5'h12, 5'h11};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tr_valid = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, ptr;
    logic [15:0] tr_sid = 16'h0, esid;
    logic [3:0] lat = 4'h0;
    logic cv [2] = '{1'b0, 1'b0};
    logic [2:0] cop [2] = '{3'h0, 3'h0};
    logic [2:0] ns_in = 3'h0, s_in = 3'h0;
    logic er, ab, evt_seen;
    logic [1:0] ecode;
    logic [4:0] got;
    wire [31:0] prdata, fetch_addr;
    wire pready, pslverr, tr_ready, tr_done, tr_abort, fetch_req, fetch_valid, evt_valid;
    wire [4:0] nso, so;
    wire [5:0] cd_fetch_attr, fetch_attr;
    wire [63:0] fetch_data;
    wire [1:0] evt_code;
    wire [15:0] evt_sid;
    int err_count = 0, cmp_count = 0, cyc = 0, nsn = 0;
    logic [31:0] flog [$];

    sbw_top sbw_top_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .ns_cmd_valid(cv[0]), .ns_cmd_op(cop[0]),
        .ns_cmd_ready(nso[4]), .ns_inval_issue(nso[3]), .ns_atc_issue(nso[2]),
        .ns_stall_resp(nso[1]), .ns_sync_done(nso[0]), .ns_inval_done(ns_in[0]),
        .ns_atc_done(ns_in[1]), .ns_atc_fail(ns_in[2]), .s_cmd_valid(cv[1]),
        .s_cmd_op(cop[1]), .s_cmd_ready(so[4]), .s_inval_issue(so[3]), .s_atc_issue(so[2]),
        .s_stall_resp(so[1]), .s_sync_done(so[0]), .s_inval_done(s_in[0]),
        .s_atc_done(s_in[1]), .s_atc_fail(s_in[2]), .tr_valid, .tr_sid, .tr_ready, .tr_done,
        .tr_abort, .cd_fetch_attr, .fetch_req, .fetch_addr, .fetch_attr, .fetch_valid,
        .fetch_data, .evt_valid, .evt_code, .evt_sid);
    sbw_mem_model sbw_mem_model_inst (.pclk, .presetn, .fetch_req, .fetch_addr, .lat,
        .fetch_valid, .fetch_data);

    initial forever #20 pclk = ~pclk;

    task finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (fetch_valid === 1'b1)
            flog.push_back(fetch_addr);
        if (evt_valid === 1'b1)
        begin
            evt_seen = 1'b1;
            ecode = evt_code;
            esid = evt_sid;
        end
        if (cyc == 30000)
        begin
            err_count++;
            finish_test();
        end
    end

    task chk(input string nm, input logic [63:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task cmd(input int q, input logic [2:0] op, input int lim);
        int n;
        @(posedge pclk);
        cv[q] <= 1'b1;
        cop[q] <= op;
        got = 5'h0;
        for (n = 0; n < lim && got[4] !== 1'b1; n++)
        begin
            @(posedge pclk);
            #1 got = q ? so : nso;
        end
        @(posedge pclk);
        cv[q] <= 1'b0;
        nsn += (q == 0 && got[4] === 1'b1);
    endtask

    task comp(input int q, input int k);
        @(posedge pclk);
        if (q)
            s_in[k] <= 1'b1;
        else
            ns_in[k] <= 1'b1;
        @(posedge pclk);
        s_in <= 3'h0;
        ns_in <= 3'h0;
    endtask

    task look(input logic [15:0] sid);
        evt_seen = 1'b0;
        flog.delete();
        @(posedge pclk);
        tr_valid <= 1'b1;
        tr_sid <= sid;
        @(posedge pclk);
        tr_valid <= 1'b0;
        while (tr_done !== 1'b1)
            @(posedge pclk);
        ab = tr_abort;
        repeat (2) @(posedge pclk);
    endtask

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1, `SBW_OFF_BASE, 32'h1000);
        apb(1, `SBW_OFF_TATTR, 32'h15);
        apb(1, `SBW_OFF_CTRL, 32'h1);
        foreach (rows[i])
        begin
            ptr = 32'h0001_0000 * (i + 1);
            sbw_mem_model_inst.mem[32'h1000 + (i + 1) * 8] =
                rows[i].l1x | ptr | rows[i].span;
            sbw_mem_model_inst.mem[ptr + rows[i].low * 64] = rows[i].ent;
            lat <= i[0] ? 4'h3 : 4'h0;
            look({i[7:0] + 8'h01, rows[i].low});
            chk("abort", rows[i].ab, ab);
            chk("event code", rows[i].code, evt_seen ? ecode : 2'h0);
            chk("l1 address", 32'h1000 + (i + 1) * 8, flog[0]);
            if (!rows[i].ab)
                chk("ctx attr", rows[i].ent[13:8], cd_fetch_attr);
            if (!rows[i].ab)
                chk("entry address", ptr + rows[i].low * 64, flog[1]);
            if (rows[i].ab)
                chk("event sid", {i[7:0] + 8'h01, rows[i].low}, esid);
        end
        for (int q = 0; q < 2; q++)
        begin
            for (int op = 0; op < 7; op++)
            begin
                cmd(q, op[2:0], 20);
                chk("cmd pulses", cexp[op], got);
            end
            comp(q, 0);
            comp(q, 0);
            comp(q, 1);
            cmd(q, `SBW_OP_SYNC, 20);
            chk("sync pulses", cexp[7], got);
        end
        apb(0, `SBW_OFF_NSCONS, 32'h0);
        chk("consumer index", nsn, rd);
        @(posedge pclk);
        presetn <= 1'b0;
        nsn = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 32; a += 4)
        begin
            apb(0, a[7:0], 32'h0);
            chk("reset value", a == 12 ? 32'h8 : 32'h0, rd);
            chk("slverr", a == 32, er);
        end
        apb(1, `SBW_OFF_BASE, 32'h1000);
        apb(1, `SBW_OFF_TATTR, 32'h15);
        look(16'h0202);
        chk("abort no record", 2'h2, {ab, evt_seen});
        apb(1, `SBW_OFF_CTRL, 32'h1);
        cmd(0, `SBW_OP_TLBI, 20);
        cmd(0, `SBW_OP_ATC, 20);
        comp(0, 2);
        cmd(0, `SBW_OP_SYNC, 12);
        chk("errored sync taken", 1'b0, got[4]);
        apb(0, `SBW_OFF_STAT, 32'h0);
        chk("sync error flag", 32'h1, rd);
        apb(0, `SBW_OFF_NSCONS, 32'h0);
        chk("consumer index", nsn, rd);
        cmd(1, `SBW_OP_SYNC, 20);
        chk("secure sync", cexp[7], got);
        apb(1, `SBW_OFF_CTRL, 32'h3);
        cmd(0, `SBW_OP_SYNC, 8);
        chk("sync waits for tlbi", 1'b0, got[4]);
        comp(0, 0);
        cmd(0, `SBW_OP_SYNC, 20);
        chk("resubmitted sync", cexp[7], got);
        apb(0, `SBW_OFF_STAT, 32'h0);
        chk("error cleared", 32'h0, rd);
        apb(0, `SBW_OFF_NSCONS, 32'h0);
        chk("consumer index", nsn, rd);
        finish_test();
    end
endmodule

bind sbw_top sbw_top_sva sbw_top_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .paddr, .pwdata, .ns_cmd_valid, .ns_cmd_ready, .ns_atc_issue, .ns_stall_resp,
    .ns_sync_done, .ns_atc_fail, .s_atc_fail, .s_cmd_valid, .s_cmd_ready, .ns_cmd_op,
    .s_cmd_op, .tr_valid, .tr_ready, .fetch_req, .fetch_attr);
